// ---- rtl/padb_map.svh ----
/*
  Constants of the power aware domain bridge: widths, reset values and field limits.
  Assumes inclusion by bare name from each bridge file; holds definitions only.
*/
`ifndef PADB_MAP_SVH
`define PADB_MAP_SVH

// Width of a transaction address and of a data word.
`define PADB_ADDR_W 32
`define PADB_DATA_W 32
// Width of the open-transaction counter.
`define PADB_CNT_W 4
// Counter value at which the bridge is idle.
`define PADB_CNT_IDLE 4'h0
// Reset value of the clamped crossing lines and of data registers.
`define PADB_CLAMP_LVL 1'b0
`define PADB_DATA_RST 32'h0000_0000
`define PADB_ADDR_RST 32'h0000_0000

`endif

// ---- rtl/padb_pkg.sv ----
/*
  Types of the power aware domain bridge: state encodings of both halves.
  Assumes the map header is compiled alongside for the numeric constants.
*/
package padb_pkg;

  // Slave half: idle, waiting for the far half, holding an answer upstream.
  typedef enum logic [1:0] {
    PADB_S_IDLE = 2'b00,
    PADB_S_WAIT = 2'b01,
    PADB_S_RESP = 2'b10
  } padb_slv_state_e;

  // Master half: idle, issuing downstream, awaiting answer, acknowledging.
  typedef enum logic [1:0] {
    PADB_M_IDLE  = 2'b00,
    PADB_M_ISSUE = 2'b01,
    PADB_M_WRSP  = 2'b10,
    PADB_M_ACK   = 2'b11
  } padb_mst_state_e;

endpackage

// ---- rtl/padb_mst_half.sv ----
/*
  Master-side half of the bridge: takes a held request from the slave half over a
  four-phase level handshake and runs it on the downstream bus.
  Assumes the slave half holds its payload stable while its request line is high.
*/
`include "padb_map.svh"

module padb_mst_half
  import padb_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    rst_mst,
  input  wire logic                    ce_mst,
  input  wire logic                    slv_pwr_ok,
  input  wire logic                    x_req,
  input  wire logic                    x_write,
  input  wire logic [`PADB_ADDR_W-1:0] x_addr,
  input  wire logic [`PADB_DATA_W-1:0] x_wdata,
  output logic                         x_ack,
  output logic                         x_err,
  output logic      [`PADB_DATA_W-1:0] x_rdata,
  output logic                         dn_req_valid,
  input  wire logic                    dn_req_ready,
  output logic                         dn_req_write,
  output logic      [`PADB_ADDR_W-1:0] dn_req_addr,
  output logic      [`PADB_DATA_W-1:0] dn_req_wdata,
  input  wire logic                    dn_rsp_valid,
  output logic                         dn_rsp_ready,
  input  wire logic                    dn_rsp_err,
  input  wire logic [`PADB_DATA_W-1:0] dn_rsp_rdata
);

  padb_mst_state_e             state;
  padb_mst_state_e             next_state;
  logic                        req_m1;
  logic                        req_s;
  logic                        next_dn_req_valid;
  logic                        next_dn_rsp_ready;
  logic                        next_dn_req_write;
  logic [`PADB_ADDR_W-1:0]     next_dn_req_addr;
  logic [`PADB_DATA_W-1:0]     next_dn_req_wdata;
  logic                        next_x_ack;
  logic                        next_x_err;
  logic [`PADB_DATA_W-1:0]     next_x_rdata;
  logic                        req_clamped;

  // A powered-off slave half must read here as an idle request line.
  assign req_clamped = x_req & slv_pwr_ok;

  // Request line enters this domain through two flip-flops.
  always_ff @(posedge clk_sys) begin
    if (rst_mst) begin
      req_m1 <= `PADB_CLAMP_LVL;
      req_s  <= `PADB_CLAMP_LVL;
    end else begin
      req_m1 <= req_clamped;
      req_s  <= req_m1;
    end
  end

  // Next state of the downstream sequencer; bus handshakes are honoured on every edge.
  always_comb begin
    next_state        = state;
    next_dn_req_valid = dn_req_valid;
    next_dn_rsp_ready = dn_rsp_ready;
    next_dn_req_write = dn_req_write;
    next_dn_req_addr  = dn_req_addr;
    next_dn_req_wdata = dn_req_wdata;
    next_x_ack        = x_ack;
    next_x_err        = x_err;
    next_x_rdata      = x_rdata;
    case (state)
      PADB_M_IDLE: begin
        if (ce_mst && req_s) begin
          next_state        = PADB_M_ISSUE;
          next_dn_req_valid = 1'b1;
          next_dn_req_write = x_write & slv_pwr_ok;
          next_dn_req_addr  = x_addr & {`PADB_ADDR_W{slv_pwr_ok}};
          next_dn_req_wdata = x_wdata & {`PADB_DATA_W{slv_pwr_ok}};
        end
      end
      PADB_M_ISSUE: begin
        if (dn_req_ready) begin
          next_state        = PADB_M_WRSP;
          next_dn_req_valid = 1'b0;
          next_dn_rsp_ready = 1'b1;
        end
      end
      PADB_M_WRSP: begin
        if (dn_rsp_valid) begin
          next_state        = PADB_M_ACK;
          next_dn_rsp_ready = 1'b0;
          next_x_err        = dn_rsp_err;
          next_x_rdata      = dn_rsp_rdata;
          next_x_ack        = 1'b1;
        end
      end
      PADB_M_ACK: begin
        if (ce_mst && !req_s) begin
          next_state = PADB_M_IDLE;
          next_x_ack = 1'b0;
        end
      end
      default: begin
        next_state = PADB_M_IDLE;
      end
    endcase
  end

  // Registers of the master half, cleared by its own reset only.
  always_ff @(posedge clk_sys) begin
    if (rst_mst) begin
      state        <= PADB_M_IDLE;
      dn_req_valid <= 1'b0;
      dn_rsp_ready <= 1'b0;
      dn_req_write <= 1'b0;
      dn_req_addr  <= `PADB_ADDR_RST;
      dn_req_wdata <= `PADB_DATA_RST;
      x_ack        <= 1'b0;
      x_err        <= 1'b0;
      x_rdata      <= `PADB_DATA_RST;
    end else begin
      state        <= next_state;
      dn_req_valid <= next_dn_req_valid;
      dn_rsp_ready <= next_dn_rsp_ready;
      dn_req_write <= next_dn_req_write;
      dn_req_addr  <= next_dn_req_addr;
      dn_req_wdata <= next_dn_req_wdata;
      x_ack        <= next_x_ack;
      x_err        <= next_x_err;
      x_rdata      <= next_x_rdata;
    end
  end

endmodule // padb_mst_half

// ---- rtl/padb_bridge.sv ----
/*
  Top of the power aware domain bridge: the slave half facing the upstream master,
  the open-transaction counter and the power-down handshake, plus the master half.
  Assumes the power manager and both buses are synchronous to clk_sys; each half
  steps at its own rate set by a one-cycle enable and has its own reset.
*/
// Overview of operation
// - Bridge is split into a slave half and a master half, each self-contained.
// - Request and acknowledge lines crossing between halves pass a two-flop synchroniser; payload lines do not.
// - Halves step at independent rates and reset independently.
// - Lines from a powered-off half are clamped to defined idle values.
// - A power-down request is recorded as pending until the handshake completes.
// - New transactions while pending get an error and are not forwarded.
// - Transactions open before the request complete normally; counter tracks them.
// - Acknowledge rises once the counter is zero with a request pending.
// - Power manager shuts the interconnect only after every bridge acknowledges.
`include "padb_map.svh"

module padb_bridge
  import padb_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic                    rst_mst,
  input  wire logic                    ce_slv,
  input  wire logic                    ce_mst,
  input  wire logic                    slv_pwr_ok,
  input  wire logic                    mst_pwr_ok,
  input  wire logic                    power_manager_dn_req,
  output logic                         power_manager_dn_ack,
  output logic                         dn_pending,
  output logic      [`PADB_CNT_W-1:0]  open_count,
  input  wire logic                    up_req_valid,
  output logic                         up_req_ready,
  input  wire logic                    up_req_write,
  input  wire logic [`PADB_ADDR_W-1:0] up_req_addr,
  input  wire logic [`PADB_DATA_W-1:0] up_req_wdata,
  output logic                         up_rsp_valid,
  input  wire logic                    up_rsp_ready,
  output logic                         up_rsp_err,
  output logic      [`PADB_DATA_W-1:0] up_rsp_rdata,
  output logic                         dn_req_valid,
  input  wire logic                    dn_req_ready,
  output logic                         dn_req_write,
  output logic      [`PADB_ADDR_W-1:0] dn_req_addr,
  output logic      [`PADB_DATA_W-1:0] dn_req_wdata,
  input  wire logic                    dn_rsp_valid,
  output logic                         dn_rsp_ready,
  input  wire logic                    dn_rsp_err,
  input  wire logic [`PADB_DATA_W-1:0] dn_rsp_rdata
);

  padb_slv_state_e             state;
  padb_slv_state_e             next_state;
  logic                        x_req;
  logic                        x_write;
  logic [`PADB_ADDR_W-1:0]     x_addr;
  logic [`PADB_DATA_W-1:0]     x_wdata;
  logic                        x_ack;
  logic                        x_err;
  logic [`PADB_DATA_W-1:0]     x_rdata;
  logic                        ack_clamped;
  logic                        ack_m1;
  logic                        ack_s;
  logic                        accept;
  logic                        forwarded;
  logic                        fwd_open;
  logic                        next_fwd_open;
  logic                        next_x_req;
  logic                        next_x_write;
  logic [`PADB_ADDR_W-1:0]     next_x_addr;
  logic [`PADB_DATA_W-1:0]     next_x_wdata;
  logic                        next_up_req_ready;
  logic                        next_up_rsp_valid;
  logic                        next_up_rsp_err;
  logic [`PADB_DATA_W-1:0]     next_up_rsp_rdata;
  logic                        done;
  logic [`PADB_CNT_W-1:0]      next_open_count;
  logic                        next_dn_pending;
  logic                        next_power_manager_dn_ack;

  // Master half lives in its own reset and power domain.
  padb_mst_half u_mst (
    .clk_sys      (clk_sys),
    .rst_mst      (rst_mst),
    .ce_mst       (ce_mst),
    .slv_pwr_ok   (slv_pwr_ok),
    .x_req        (x_req),
    .x_write      (x_write),
    .x_addr       (x_addr),
    .x_wdata      (x_wdata),
    .x_ack        (x_ack),
    .x_err        (x_err),
    .x_rdata      (x_rdata),
    .dn_req_valid (dn_req_valid),
    .dn_req_ready (dn_req_ready),
    .dn_req_write (dn_req_write),
    .dn_req_addr  (dn_req_addr),
    .dn_req_wdata (dn_req_wdata),
    .dn_rsp_valid (dn_rsp_valid),
    .dn_rsp_ready (dn_rsp_ready),
    .dn_rsp_err   (dn_rsp_err),
    .dn_rsp_rdata (dn_rsp_rdata)
  );

  // A powered-off master half reads here as a low acknowledge line.
  assign ack_clamped = x_ack & mst_pwr_ok;

  // Acknowledge line enters the slave domain through two flip-flops.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_m1 <= `PADB_CLAMP_LVL;
      ack_s  <= `PADB_CLAMP_LVL;
    end else begin
      ack_m1 <= ack_clamped;
      ack_s  <= ack_m1;
    end
  end

  // Handshakes on the upstream bus are honoured on every edge, independent of ce_slv.
  assign accept = up_req_valid & up_req_ready;
  assign done   = up_rsp_valid & up_rsp_ready;
  assign forwarded = accept & ~dn_pending;

  // Next state of the slave half sequencer.
  always_comb begin
    next_state        = state;
    next_fwd_open     = fwd_open;
    next_x_req        = x_req;
    next_x_write      = x_write;
    next_x_addr       = x_addr;
    next_x_wdata      = x_wdata;
    next_up_rsp_valid = up_rsp_valid;
    next_up_rsp_err   = up_rsp_err;
    next_up_rsp_rdata = up_rsp_rdata;
    case (state)
      PADB_S_IDLE: begin
        if (accept && dn_pending) begin
          next_state        = PADB_S_RESP;
          next_fwd_open     = 1'b0;
          next_up_rsp_valid = 1'b1;
          next_up_rsp_err   = 1'b1;
          next_up_rsp_rdata = `PADB_DATA_RST;
        end else if (accept) begin
          next_state    = PADB_S_WAIT;
          next_fwd_open = 1'b1;
          next_x_req    = 1'b1;
          next_x_write  = up_req_write;
          next_x_addr   = up_req_addr;
          next_x_wdata  = up_req_wdata;
        end
      end
      PADB_S_WAIT: begin
        if (ce_slv && ack_s) begin
          next_state        = PADB_S_RESP;
          next_x_req        = 1'b0;
          next_up_rsp_valid = 1'b1;
          next_up_rsp_err   = x_err & mst_pwr_ok;
          next_up_rsp_rdata = x_rdata & {`PADB_DATA_W{mst_pwr_ok}};
        end
      end
      PADB_S_RESP: begin
        if (done) begin
          next_state        = PADB_S_IDLE;
          next_fwd_open     = 1'b0;
          next_up_rsp_valid = 1'b0;
        end
      end
      default: begin
        next_state = PADB_S_IDLE;
      end
    endcase
    // Ready rises on an own step only, once the far half has dropped its acknowledge.
    next_up_req_ready = up_req_ready & ~accept;
    if (ce_slv && next_state == PADB_S_IDLE && !ack_s && !accept) begin
      next_up_req_ready = 1'b1;
    end
  end

  // Registers of the slave half sequencer.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state        <= PADB_S_IDLE;
      fwd_open     <= 1'b0;
      x_req        <= 1'b0;
      x_write      <= 1'b0;
      x_addr       <= `PADB_ADDR_RST;
      x_wdata      <= `PADB_DATA_RST;
      up_req_ready <= 1'b0;
      up_rsp_valid <= 1'b0;
      up_rsp_err   <= 1'b0;
      up_rsp_rdata <= `PADB_DATA_RST;
    end else begin
      state        <= next_state;
      fwd_open     <= next_fwd_open;
      x_req        <= next_x_req;
      x_write      <= next_x_write;
      x_addr       <= next_x_addr;
      x_wdata      <= next_x_wdata;
      up_req_ready <= next_up_req_ready;
      up_rsp_valid <= next_up_rsp_valid;
      up_rsp_err   <= next_up_rsp_err;
      up_rsp_rdata <= next_up_rsp_rdata;
    end
  end

  // Open-transaction count and the power-down handshake with the power manager.
  always_comb begin
    next_open_count = open_count;
    if (forwarded && !(done && fwd_open)) begin
      next_open_count = open_count + `PADB_CNT_W'(1);
    end else if (done && fwd_open && !forwarded) begin
      next_open_count = open_count - `PADB_CNT_W'(1);
    end
    // Pending is set by the request and cleared only after it was acknowledged and dropped.
    next_dn_pending = dn_pending;
    if (power_manager_dn_req) begin
      next_dn_pending = 1'b1;
    end else if (power_manager_dn_ack) begin
      next_dn_pending = 1'b0;
    end
    // Acknowledge tells the power manager the attached party may be shut down.
    next_power_manager_dn_ack = next_dn_pending && (next_open_count == `PADB_CNT_IDLE);
  end

  // Registers of the counter and the power-down handshake.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      open_count           <= `PADB_CNT_IDLE;
      dn_pending           <= 1'b0;
      power_manager_dn_ack <= 1'b0;
    end else begin
      open_count           <= next_open_count;
      dn_pending           <= next_dn_pending;
      power_manager_dn_ack <= next_power_manager_dn_ack;
    end
  end

endmodule // padb_bridge

// ---- tb/padb_properties.sv ----
/*
  Checker of the bridge top: request logging, rejection, counting and acknowledge.
  Assumes it is bound to padb_bridge; watched ports belong to clk_sys and rst, except dn_req_valid, which is reset by rst_mst.
*/
`include "padb_map.svh"

module padb_properties (
  input wire logic                    clk_sys,
  input wire logic                    rst,
  input wire logic                    power_manager_dn_req,
  input wire logic                    power_manager_dn_ack,
  input wire logic                    dn_pending,
  input wire logic [`PADB_CNT_W-1:0]  open_count,
  input wire logic                    up_req_valid,
  input wire logic                    up_req_ready,
  input wire logic                    up_rsp_valid,
  input wire logic                    up_rsp_ready,
  input wire logic                    up_rsp_err,
  input wire logic [`PADB_DATA_W-1:0] up_rsp_rdata,
  input wire logic                    dn_req_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // Every check steps on the system clock and rests while the slave half is in reset.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_log; power_manager_dn_req |=> dn_pending; endproperty
  a_log: assert property (p_log) else $error("request not logged");
  property p_keep;
    dn_pending && !(!power_manager_dn_req && power_manager_dn_ack) |=> dn_pending;
  endproperty
  a_keep: assert property (p_keep) else $error("pending lost early");
  property p_rej;
    up_req_valid && up_req_ready && dn_pending
      |=> up_rsp_valid && up_rsp_err && up_rsp_rdata == `PADB_DATA_RST;
  endproperty
  a_rej: assert property (p_rej) else $error("new request not refused");
  property p_nofwd; up_req_valid && up_req_ready && dn_pending |=> !dn_req_valid [*8]; endproperty
  a_nofwd: assert property (p_nofwd) else $error("refused request forwarded");
  property p_ack;
    dn_pending && power_manager_dn_req && open_count == `PADB_CNT_IDLE |=> power_manager_dn_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge missing");
  property p_ackp; power_manager_dn_ack |-> dn_pending; endproperty
  a_ackp: assert property (p_ackp) else $error("acknowledge without pending");
  property p_open; open_count != `PADB_CNT_IDLE |-> !power_manager_dn_ack; endproperty
  a_open: assert property (p_open) else $error("acknowledge while open");
  property p_inc;
    up_req_valid && up_req_ready && !dn_pending |=> open_count == $past(open_count) + 1'b1;
  endproperty
  a_inc: assert property (p_inc) else $error("count not raised");
  property p_dec;
    up_rsp_valid && up_rsp_ready && !up_rsp_err |=> open_count == $past(open_count) - 1'b1;
  endproperty
  a_dec: assert property (p_dec) else $error("count not lowered");
endmodule // padb_properties

bind padb_bridge padb_properties u_padb_props (
  .clk_sys(clk_sys), .rst(rst), .power_manager_dn_req(power_manager_dn_req),
  .power_manager_dn_ack(power_manager_dn_ack), .dn_pending(dn_pending),
  .open_count(open_count), .up_req_valid(up_req_valid), .up_req_ready(up_req_ready),
  .up_rsp_valid(up_rsp_valid), .up_rsp_ready(up_rsp_ready), .up_rsp_err(up_rsp_err),
  .up_rsp_rdata(up_rsp_rdata), .dn_req_valid(dn_req_valid)
);

// ---- tb/padb_dn_slave.sv ----
/*
  Downstream slave model: a one-word store that accepts and answers after lat+1 cycles each.
  Assumes the bridge holds each request until ready and keeps response ready up.
*/
`include "padb_map.svh"

module padb_dn_slave (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_mst,
  input  wire logic [3:0]              lat,
  input  wire logic                    dn_req_valid,
  output logic                         dn_req_ready,
  input  wire logic                    dn_req_write,
  input  wire logic [`PADB_DATA_W-1:0] dn_req_wdata,
  output logic                         dn_rsp_valid,
  input  wire logic                    dn_rsp_ready,
  output logic [`PADB_DATA_W-1:0]      dn_rsp_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]              wait_cnt;
  logic                    busy;
  logic [`PADB_DATA_W-1:0] mem;

  // Waits lat+1 cycles to accept and lat+1 more to answer; idle read data toggles.
  always_ff @(posedge clk_sys) begin
    if (rst_mst) begin
      wait_cnt <= 4'h0;
      busy <= 1'b0;
      dn_req_ready <= 1'b0;
      dn_rsp_valid <= 1'b0;
      dn_rsp_rdata <= 32'h0;
    end else begin
      dn_req_ready <= 1'b0;
      if (!dn_rsp_valid) dn_rsp_rdata <= ~dn_rsp_rdata;
      if (!busy && dn_req_valid && !dn_req_ready) begin
        wait_cnt <= (wait_cnt == lat) ? 4'h0 : wait_cnt + 4'h1;
        dn_req_ready <= (wait_cnt == lat);
      end
      if (dn_req_valid && dn_req_ready) begin
        busy <= 1'b1;
        if (dn_req_write) mem <= dn_req_wdata;
      end
      if (busy && !dn_rsp_valid) begin
        wait_cnt <= (wait_cnt == lat) ? 4'h0 : wait_cnt + 4'h1;
        if (wait_cnt == lat) begin
          dn_rsp_valid <= 1'b1;
          dn_rsp_rdata <= mem;
        end
      end
      if (dn_rsp_valid && dn_rsp_ready) begin
        dn_rsp_valid <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule // padb_dn_slave

// ---- tb/test_power_aware_domain_bridge.sv ----
/*
  Bench of the bridge: plain transfers, refusal while power-down pends, drain, and a clamped slave half.
  Assumes the bridge top, its bound checker and the downstream slave model.
*/
`include "padb_map.svh"

module test_power_aware_domain_bridge;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rst, rst_mst, dn_req, ack, pend, rq_v, rq_r, rq_w, rs_v, rs_r, rs_e;
  logic        d_v, d_r, d_w, d_rv, d_rr, ce_mst, slv_pwr_ok;
  logic [3:0]  open_count, lat;
  logic [31:0] rq_a, rq_d, rs_d, d_a, d_wd, d_rd, e, r;
  int          miscompares, checks_done;

  padb_bridge DUT (
    .clk_sys(clk_sys), .rst(rst), .rst_mst(rst_mst), .ce_slv(1'b1), .ce_mst(ce_mst),
    .slv_pwr_ok(slv_pwr_ok), .mst_pwr_ok(1'b1), .power_manager_dn_req(dn_req),
    .power_manager_dn_ack(ack), .dn_pending(pend), .open_count(open_count),
    .up_req_valid(rq_v), .up_req_ready(rq_r), .up_req_write(rq_w), .up_req_addr(rq_a),
    .up_req_wdata(rq_d), .up_rsp_valid(rs_v), .up_rsp_ready(rs_r), .up_rsp_err(rs_e),
    .up_rsp_rdata(rs_d), .dn_req_valid(d_v), .dn_req_ready(d_r), .dn_req_write(d_w),
    .dn_req_addr(d_a), .dn_req_wdata(d_wd), .dn_rsp_valid(d_rv), .dn_rsp_ready(d_rr),
    .dn_rsp_err(1'b0), .dn_rsp_rdata(d_rd));
  padb_dn_slave u_slave (
    .clk_sys(clk_sys), .rst_mst(rst_mst), .lat(lat), .dn_req_valid(d_v),
    .dn_req_ready(d_r), .dn_req_write(d_w), .dn_req_wdata(d_wd), .dn_rsp_valid(d_rv),
    .dn_rsp_ready(d_rr), .dn_rsp_rdata(d_rd));

  // Free-running 250 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One upstream transfer: hold the request until taken, then wait for the answer.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] oe, output logic [31:0] od);
    int n;
    @(posedge clk_sys);
    rq_v <= 1'b1;
    rq_w <= w;
    rq_a <= a;
    rq_d <= d;
    rs_r <= 1'b1;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (rq_r !== 1'b1 && n < 100);
    rq_v <= 1'b0;
    // A request that was never taken counts as a timeout.
    if (rq_r !== 1'b1) n = 200;
    do begin @(posedge clk_sys); n++; end while (rs_v !== 1'b1 && n < 200);
    oe = {31'h0, rs_e};
    od = rs_d;
    rs_r <= 1'b0;
    // One edge more, so that callers see the count and acknowledge left by the taking edge.
    @(posedge clk_sys);
    if (n >= 200) begin
      miscompares++;
      tally_and_finish();
    end
  endtask

  task automatic wait_ack();
    int n;
    n = 0;
    while (ack !== 1'b1 && n < 200) begin @(posedge clk_sys); n++; end
    check(n < 200, 1'b1);
  endtask

  // Writes then reads back, with a prompt and a slow slave.
  task automatic t_plain();
    for (int i = 0; i < 2; i++) begin
      lat <= (i == 0) ? 4'h0 : 4'h7;
      xfer(1'b1, 32'h0000_0010, 32'h1234_5670 + i, e, r);
      check(e, 32'h0);
      xfer(1'b0, 32'h0000_0010, 32'h0, e, r);
      check(r, 32'h1234_5670 + i);
      check(open_count, `PADB_CNT_IDLE);
    end
    $display("t_plain done");
  endtask

  // Refusal while pending; the refused write must not reach the slave.
  task automatic t_reject();
    dn_req <= 1'b1;
    wait_ack();
    check(pend, 1'b1);
    xfer(1'b1, 32'h0000_0020, 32'hdead_beef, e, r);
    check(e, 32'h1);
    check(r, `PADB_DATA_RST);
    check(open_count, `PADB_CNT_IDLE);
    check(ack, 1'b1);
    dn_req <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check({ack, pend}, 32'h0);
    xfer(1'b0, 32'h0000_0020, 32'h0, e, r);
    check(e, 32'h0);
    check(r, 32'h1234_5671);
    $display("t_reject done");
  endtask

  // Request arriving while a slow transfer is open: it drains before acknowledge.
  task automatic t_drain();
    lat <= 4'h8;
    fork
      xfer(1'b0, 32'h0000_0030, 32'h0, e, r);
      begin
        repeat (8) @(posedge clk_sys);
        dn_req <= 1'b1;
        repeat (6) @(posedge clk_sys);
        check(open_count, 32'h1);
        check(ack, 1'b0);
      end
    join
    check(e, 32'h0);
    check(r, 32'h1234_5671);
    wait_ack();
    dn_req <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check(ack, 1'b0);
    $display("t_drain done");
  endtask

  // Master half reset alone, then a clamped slave half; a paced master half ends the read.
  task automatic t_clamp();
    rst_mst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst_mst <= 1'b0;
    slv_pwr_ok <= 1'b0;
    check(rq_r, 1'b1);
    fork
      xfer(1'b0, 32'h0000_0040, 32'h0, e, r);
      begin
        repeat (12) begin
          @(posedge clk_sys);
          check(d_v, 1'b0);
        end
        slv_pwr_ok <= 1'b1;
        repeat (40) begin
          @(posedge clk_sys);
          ce_mst <= ~ce_mst;
        end
        @(posedge clk_sys);
        ce_mst <= 1'b1;
      end
    join
    check(e, 32'h0);
    check(r, 32'h1234_5671);
    $display("t_clamp done");
  endtask

  // Reset both halves for 12 cycles, then run the scenarios.
  initial begin
    miscompares = 0;
    checks_done = 0;
    {rst, rst_mst} = 2'b11;
    {dn_req, rq_v, rq_w, rs_r} = 4'h0;
    {ce_mst, slv_pwr_ok} = 2'b11;
    rq_a = 32'h0;
    rq_d = 32'h0;
    lat = 4'h0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rst_mst <= 1'b0;
    t_plain();
    t_reject();
    t_drain();
    t_clamp();
    tally_and_finish();
  end
endmodule // test_power_aware_domain_bridge
